// file: amp_regs_pkg.sv
// Register map, field layouts and timing constants for the amplifier control bank
// Notes on behaviour
// - Eight-bit page register, reset 1, picks the page later accesses reach.
// - Eight-bit read-only identity register; writes never change it.
// - Ramp rate bits 5:4: 0 is 384 kHz, 1 is 352.8 kHz, 2 reserved.
// - Spread depth bits 1:0 under spread modulation: 1 is 5 %, 2 is 10 %.
// - Protection bit 2: zero enables over-temperature auto retry, one disables; reset zero.
// - Protection register resets to 3h, low two reserved bits set.
// - Auto passthrough: boost off at low power, boost on quickly at high power.
// - Load current and voltage sampled on each sense_sample pulse, streamed out as digital words.
// - After hardware or software reset, commands wait out the settings load time.
package amp_regs_pkg;

  localparam int ADDR_W = 10;
  localparam int DATA_W = 32;

  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_PAGE  = 8'h00;
  localparam logic [7:0] IDX_RAMP  = 8'h06;
  localparam logic [7:0] IDX_PROT  = 8'h09;
  localparam logic [7:0] IDX_ID    = 8'h7D;
  localparam logic [7:0] IDX_STAT  = 8'h60;
  localparam logic [7:0] IDX_MASK  = 8'h61;
  localparam logic [7:0] IDX_BOOST = 8'h62;
  localparam logic [7:0] IDX_SENSE = 8'h63;

  localparam logic [7:0] PAGE_ID  = 8'h01;
  localparam logic [7:0] PAGE_CFG = 8'h02;

  localparam logic [7:0] PAGE_RST      = 8'h01;
  localparam logic [7:0] RAMP_RST      = 8'h00;
  localparam logic [7:0] PROT_RST      = 8'h03;
  localparam logic [7:0] RAMP_WMASK    = 8'h33;
  localparam logic [7:0] PROT_WMASK    = 8'h04;
  localparam logic [7:0] BOOST_THR_RST = 8'h80;

  localparam int RAMP_FREQ_LSB  = 4;
  localparam int RAMP_DEPTH_LSB = 0;
  localparam int OT_RETRY_BIT   = 2;

  localparam logic [1:0] RAMP_384K   = 2'h0;
  localparam logic [1:0] RAMP_352K8  = 2'h1;
  localparam logic [1:0] DEPTH_5PCT  = 2'h1;
  localparam logic [1:0] DEPTH_10PCT = 2'h2;

  // Boost / mode register layout
  localparam int AUTO_PT_BIT  = 0;
  localparam int FORCE_BIT    = 1;
  localparam int SSM_BIT      = 2;
  localparam int SOFT_RST_BIT = 3;
  localparam int THR_LSB      = 8;
  localparam int BOOST_ON_BIT = 16;
  localparam int SHUTDN_BIT   = 17;

  // Interrupt events
  localparam int EV_OVERTEMP  = 0;
  localparam int EV_BOOST_ON  = 1;
  localparam int EV_SENSE     = 2;
  localparam int EV_LOAD_DONE = 3;
  localparam int NUM_EV       = 4;

  // Settings load time after reset
  localparam int CLK_PERIOD_NS = 10;
  localparam int LOAD_TIME_NS  = 100000;
  localparam int LOAD_CYCLES   = (LOAD_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int LOAD_CNT_W    = 14;

  // Boost stays on this long after demand falls
  localparam int          HOLD_W    = 4;
  localparam logic [3:0]  HOLD_LAST = 4'hF;

  typedef enum logic [3:0] {
    SEL_NONE, SEL_PAGE, SEL_RAMP, SEL_PROT, SEL_ID,
    SEL_STAT, SEL_MASK, SEL_BOOST, SEL_SENSE
  } reg_sel_e;

  typedef enum logic {LD_BUSY, LD_READY} load_state_e;

endpackage

// file: boost_ctrl_if.sv
// Signals between the register bank and the boost passthrough controller
`timescale 1ns/100ps
interface boost_ctrl_if;
  logic       auto_mode;
  logic       force_on;
  logic [7:0] threshold;
  logic [7:0] demand;
  logic       boost_on;
  logic       activated;

  modport ctrl  (output auto_mode, force_on, threshold, demand, input boost_on, activated);
  modport boost (input auto_mode, force_on, threshold, demand, output boost_on, activated);
endinterface

// file: boost_passthrough.sv
// Class-H boost on/off decision for automatic passthrough
`timescale 1ns/100ps
module boost_passthrough (
  input wire logic pclk,
  input wire logic presetn,
  boost_ctrl_if.boost bp
);

  logic                           on_q;
  logic [amp_regs_pkg::HOLD_W-1:0] hold_cnt;
  logic                           high_power;

  assign high_power = bp.demand > bp.threshold;

  // Turn on at once; turn off only after demand stays low for the hold time
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bp.boost_on <= 1'b0;
      hold_cnt    <= '0;
    end else if (!bp.auto_mode || bp.force_on || high_power) begin
      bp.boost_on <= 1'b1;
      hold_cnt    <= amp_regs_pkg::HOLD_LAST;
    end else if (hold_cnt != '0) begin
      hold_cnt <= hold_cnt - 1'b1;
    end else begin
      bp.boost_on <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      on_q <= 1'b0;
    end else begin
      on_q <= bp.boost_on;
    end
  end

  assign bp.activated = bp.boost_on & ~on_q;

  property p_boost_fast;
    @(posedge pclk) disable iff (!presetn)
    (bp.auto_mode && high_power) |=> bp.boost_on;
  endproperty
  a_boost_fast: assert property (p_boost_fast) else $error("boost not on after high demand");

  property p_passthrough_idle;
    @(posedge pclk) disable iff (!presetn)
    (bp.auto_mode && !bp.force_on && !high_power)[*8] ##1
    (bp.auto_mode && !bp.force_on && !high_power)[*8] ##1
    (bp.auto_mode && !bp.force_on && !high_power) |=> !bp.boost_on;
  endproperty
  a_passthrough_idle: assert property (p_passthrough_idle) else $error("boost left on at low power");

endmodule // boost_passthrough

// file: amp_ctrl_regs.sv
// APB register bank: paging, identity, ramp, protection, boost and load sense
`timescale 1ns/100ps
module amp_ctrl_regs #(
  parameter int unsigned LOAD_CYCLES = amp_regs_pkg::LOAD_CYCLES,
  parameter logic [7:0]  ID_CODE     = 8'hA5 // Arbitrary identity value
) (
  input  wire logic                            pclk,
  input  wire logic                            presetn,
  input  wire logic                            psel,
  input  wire logic                            penable,
  input  wire logic                            pwrite,
  input  wire logic [amp_regs_pkg::ADDR_W-1:0] paddr,
  input  wire logic [amp_regs_pkg::DATA_W-1:0] pwdata,
  input  wire logic [3:0]                      pstrb,
  output logic      [amp_regs_pkg::DATA_W-1:0] prdata,
  output logic                                 pready,
  output logic                                 pslverr,
  output logic                                 irq,
  input  wire logic                            die_overtemp,
  output logic                                 amp_shutdown,
  output logic      [1:0]                      ramp_freq_sel,
  output logic      [1:0]                      ramp_spread_depth,
  output logic                                 spread_spectrum_modulation,
  input  wire logic [7:0]                      output_demand,
  output logic                                 boost_enable,
  output logic                                 passthrough_on,
  input  wire logic                            sense_sample,
  input  wire logic [15:0]                     load_current,
  input  wire logic [15:0]                     load_voltage,
  output logic      [31:0]                     sense_stream_data,
  output logic                                 sense_stream_valid,
  output logic                                 config_loading
);

  localparam logic [amp_regs_pkg::LOAD_CNT_W-1:0] LOAD_LAST =
    amp_regs_pkg::LOAD_CNT_W'(LOAD_CYCLES - 1);

  logic [7:0]                        page_sel;
  logic [7:0]                        ramp_reg;
  logic [7:0]                        prot_reg;
  logic [7:0]                        thr;
  logic                              auto_pt;
  logic                              force_boost;
  logic                              ssm_en;
  logic [amp_regs_pkg::NUM_EV-1:0]   stat;
  logic [amp_regs_pkg::NUM_EV-1:0]   mask;
  logic [amp_regs_pkg::NUM_EV-1:0]   ev;
  logic [amp_regs_pkg::NUM_EV-1:0]   clr;
  logic                              ot_q;
  amp_regs_pkg::load_state_e         load_state;
  logic [amp_regs_pkg::LOAD_CNT_W-1:0] load_cnt;
  logic                              load_done;
  amp_regs_pkg::reg_sel_e            sel;
  logic                              setup;
  logic                              wr_go;
  logic                              wr_lo;
  logic                              soft_rst;
  logic                              retry_en;
  logic [amp_regs_pkg::DATA_W-1:0]   rdata;

  boost_ctrl_if bif ();

  // Maps page and byte address to a register
  function automatic amp_regs_pkg::reg_sel_e decode(
    input logic [7:0]                      pg,
    input logic [amp_regs_pkg::ADDR_W-1:0] a
  );
    logic [7:0] idx;
    idx    = a[amp_regs_pkg::ADDR_W-1:2];
    decode = amp_regs_pkg::SEL_NONE;
    if (a[1:0] == 2'h0) begin
      case (idx)
        amp_regs_pkg::IDX_PAGE:  decode = amp_regs_pkg::SEL_PAGE;
        amp_regs_pkg::IDX_STAT:  decode = amp_regs_pkg::SEL_STAT;
        amp_regs_pkg::IDX_MASK:  decode = amp_regs_pkg::SEL_MASK;
        amp_regs_pkg::IDX_BOOST: decode = amp_regs_pkg::SEL_BOOST;
        amp_regs_pkg::IDX_SENSE: decode = amp_regs_pkg::SEL_SENSE;
        amp_regs_pkg::IDX_RAMP: begin
          if (pg == amp_regs_pkg::PAGE_CFG) decode = amp_regs_pkg::SEL_RAMP;
        end
        amp_regs_pkg::IDX_PROT: begin
          if (pg == amp_regs_pkg::PAGE_CFG) decode = amp_regs_pkg::SEL_PROT;
        end
        amp_regs_pkg::IDX_ID: begin
          if (pg == amp_regs_pkg::PAGE_ID) decode = amp_regs_pkg::SEL_ID;
        end
        default: decode = amp_regs_pkg::SEL_NONE;
      endcase
    end
  endfunction

  // Only writable bits change; reserved bits keep their value
  function automatic logic [7:0] merge(
    input logic [7:0] old,
    input logic [7:0] wdat,
    input logic [7:0] wmask
  );
    merge = (old & ~wmask) | (wdat & wmask);
  endfunction

  assign sel      = decode(page_sel, paddr);
  assign setup    = psel && !penable;
  assign pready   = (load_state == amp_regs_pkg::LD_READY);
  assign wr_go    = psel && penable && pwrite && pready;
  assign wr_lo    = wr_go && pstrb[0];
  assign pslverr  = psel && penable && pready && (sel == amp_regs_pkg::SEL_NONE);
  assign soft_rst = wr_lo && (sel == amp_regs_pkg::SEL_BOOST) && pwdata[amp_regs_pkg::SOFT_RST_BIT];

  // Settings load after hardware or software reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      load_state <= amp_regs_pkg::LD_BUSY;
      load_cnt   <= '0;
    end else begin
      case (load_state)
        amp_regs_pkg::LD_BUSY: begin
          if (load_cnt == LOAD_LAST) begin
            load_state <= amp_regs_pkg::LD_READY;
            load_cnt   <= '0;
          end else begin
            load_cnt <= load_cnt + 1'b1;
          end
        end
        amp_regs_pkg::LD_READY: begin
          if (soft_rst) load_state <= amp_regs_pkg::LD_BUSY;
        end
        default: load_state <= amp_regs_pkg::LD_BUSY;
      endcase
    end
  end

  assign load_done      = (load_state == amp_regs_pkg::LD_BUSY) && (load_cnt == LOAD_LAST);
  assign config_loading = (load_state == amp_regs_pkg::LD_BUSY);

  // Page, ramp and protection registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      page_sel <= amp_regs_pkg::PAGE_RST;
      ramp_reg <= amp_regs_pkg::RAMP_RST;
      prot_reg <= amp_regs_pkg::PROT_RST;
    end else if (soft_rst) begin
      page_sel <= amp_regs_pkg::PAGE_RST;
      ramp_reg <= amp_regs_pkg::RAMP_RST;
      prot_reg <= amp_regs_pkg::PROT_RST;
    end else if (wr_lo) begin
      case (sel)
        amp_regs_pkg::SEL_PAGE: page_sel <= pwdata[7:0];
        amp_regs_pkg::SEL_RAMP: ramp_reg <= merge(ramp_reg, pwdata[7:0], amp_regs_pkg::RAMP_WMASK);
        amp_regs_pkg::SEL_PROT: prot_reg <= merge(prot_reg, pwdata[7:0], amp_regs_pkg::PROT_WMASK);
        default: ;
      endcase
    end
  end

  // Boost mode, spread enable and threshold
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      auto_pt     <= 1'b1;
      force_boost <= 1'b0;
      ssm_en      <= 1'b0;
      thr         <= amp_regs_pkg::BOOST_THR_RST;
    end else if (wr_go && sel == amp_regs_pkg::SEL_BOOST) begin
      if (pstrb[0]) begin
        auto_pt     <= pwdata[amp_regs_pkg::AUTO_PT_BIT];
        force_boost <= pwdata[amp_regs_pkg::FORCE_BIT];
        ssm_en      <= pwdata[amp_regs_pkg::SSM_BIT];
      end
      if (pstrb[1]) thr <= pwdata[amp_regs_pkg::THR_LSB +: 8];
    end
  end

  // Interrupt mask
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mask <= '0;
    end else if (wr_lo && sel == amp_regs_pkg::SEL_MASK) begin
      mask <= pwdata[amp_regs_pkg::NUM_EV-1:0];
    end
  end

  // Over-temperature edge detect
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ot_q <= 1'b0;
    end else begin
      ot_q <= die_overtemp;
    end
  end

  assign ev[amp_regs_pkg::EV_OVERTEMP]  = die_overtemp && !ot_q;
  assign ev[amp_regs_pkg::EV_BOOST_ON]  = bif.activated;
  assign ev[amp_regs_pkg::EV_SENSE]     = sense_sample;
  assign ev[amp_regs_pkg::EV_LOAD_DONE] = load_done;
  assign clr = (wr_lo && sel == amp_regs_pkg::SEL_STAT) ? pwdata[amp_regs_pkg::NUM_EV-1:0] : '0;

  // Sticky status, set beats write-one-to-clear
  for (genvar i = 0; i < amp_regs_pkg::NUM_EV; i++) begin : g_stat
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        stat[i] <= 1'b0;
      end else begin
        stat[i] <= ev[i] | (stat[i] & ~clr[i]);
      end
    end
  end

  assign irq = |(stat & mask);

  // Amplifier stays off while hot; restarts on its own only with retry enabled
  assign retry_en = !prot_reg[amp_regs_pkg::OT_RETRY_BIT];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      amp_shutdown <= 1'b0;
    end else if (die_overtemp) begin
      amp_shutdown <= 1'b1;
    end else if (retry_en || !stat[amp_regs_pkg::EV_OVERTEMP]) begin
      amp_shutdown <= 1'b0;
    end
  end

  // Ramp generator settings
  assign ramp_freq_sel              = ramp_reg[amp_regs_pkg::RAMP_FREQ_LSB +: 2];
  assign spread_spectrum_modulation = ssm_en;
  assign ramp_spread_depth          = ssm_en ? ramp_reg[amp_regs_pkg::RAMP_DEPTH_LSB +: 2] : 2'h0;

  // Boost passthrough controller
  assign bif.auto_mode = auto_pt;
  assign bif.force_on  = force_boost;
  assign bif.threshold = thr;
  assign bif.demand    = output_demand;

  boost_passthrough u_boost (
    .pclk    (pclk),
    .presetn (presetn),
    .bp      (bif.boost)
  );

  assign boost_enable   = bif.boost_on;
  assign passthrough_on = !bif.boost_on;

  // Load sense stream
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sense_stream_data  <= '0;
      sense_stream_valid <= 1'b0;
    end else begin
      sense_stream_valid <= sense_sample;
      if (sense_sample) sense_stream_data <= {load_voltage, load_current};
    end
  end

  // Read mux
  always_comb begin
    rdata = '0;
    case (sel)
      amp_regs_pkg::SEL_PAGE:  rdata[7:0] = page_sel;
      amp_regs_pkg::SEL_RAMP:  rdata[7:0] = ramp_reg;
      amp_regs_pkg::SEL_PROT:  rdata[7:0] = prot_reg;
      amp_regs_pkg::SEL_ID:    rdata[7:0] = ID_CODE;
      amp_regs_pkg::SEL_STAT:  rdata[amp_regs_pkg::NUM_EV-1:0] = stat;
      amp_regs_pkg::SEL_MASK:  rdata[amp_regs_pkg::NUM_EV-1:0] = mask;
      amp_regs_pkg::SEL_BOOST: begin
        rdata[amp_regs_pkg::AUTO_PT_BIT]  = auto_pt;
        rdata[amp_regs_pkg::FORCE_BIT]    = force_boost;
        rdata[amp_regs_pkg::SSM_BIT]      = ssm_en;
        rdata[amp_regs_pkg::THR_LSB +: 8] = thr;
        rdata[amp_regs_pkg::BOOST_ON_BIT] = bif.boost_on;
        rdata[amp_regs_pkg::SHUTDN_BIT]   = amp_shutdown;
      end
      amp_regs_pkg::SEL_SENSE: rdata = sense_stream_data;
      default:                 rdata = '0;
    endcase
  end

  // Read data captured in the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= '0;
    end else if (setup && !pwrite) begin
      prdata <= rdata;
    end
  end

  default clocking dc @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_page_write;
    (wr_lo && sel == amp_regs_pkg::SEL_PAGE && !soft_rst) |=> (page_sel == $past(pwdata[7:0]));
  endproperty
  a_page_write: assert property (p_page_write) else $error("page select did not take write");

  property p_id_read;
    (setup && !pwrite && sel == amp_regs_pkg::SEL_ID) |=> (prdata == {24'h000000, ID_CODE});
  endproperty
  a_id_read: assert property (p_id_read) else $error("identity read wrong");

  property p_ramp_freq;
    (wr_lo && sel == amp_regs_pkg::SEL_RAMP) |=> (ramp_freq_sel == $past(pwdata[amp_regs_pkg::RAMP_FREQ_LSB +: 2]));
  endproperty
  a_ramp_freq: assert property (p_ramp_freq) else $error("ramp rate not updated");

  property p_spread_depth;
    (ssm_en |-> ramp_spread_depth == ramp_reg[amp_regs_pkg::RAMP_DEPTH_LSB +: 2])
      and (!ssm_en |-> ramp_spread_depth == 2'h0);
  endproperty
  a_spread_depth: assert property (p_spread_depth) else $error("spread depth output wrong");

  property p_no_retry;
    (amp_shutdown && !die_overtemp && !retry_en && stat[amp_regs_pkg::EV_OVERTEMP]
      && !clr[amp_regs_pkg::EV_OVERTEMP]) |=> amp_shutdown;
  endproperty
  a_no_retry: assert property (p_no_retry) else $error("restart with retry disabled");

  property p_overtemp_off;
    die_overtemp |=> amp_shutdown;
  endproperty
  a_overtemp_off: assert property (p_overtemp_off) else $error("amplifier not held off when hot");

  property p_prot_reset;
    $fell(config_loading) |-> prot_reg == amp_regs_pkg::PROT_RST;
  endproperty
  a_prot_reset: assert property (p_prot_reset) else $error("protection reset value wrong");

  property p_sense_stream;
    sense_sample |=> sense_stream_valid && sense_stream_data == {$past(load_voltage), $past(load_current)};
  endproperty
  a_sense_stream: assert property (p_sense_stream) else $error("sense sample not streamed");

  property p_load_hold;
    soft_rst |=> (!pready) [*2];
  endproperty
  a_load_hold: assert property (p_load_hold) else $error("commands taken during load");

  property p_load_count;
    (config_loading && load_cnt != LOAD_LAST) |=> config_loading && load_cnt == $past(load_cnt) + 1'b1;
  endproperty
  a_load_count: assert property (p_load_count) else $error("load counter misbehaves");

  property p_reserved;
    ((prot_reg & ~amp_regs_pkg::PROT_WMASK) == (amp_regs_pkg::PROT_RST & ~amp_regs_pkg::PROT_WMASK))
      && ((ramp_reg & ~amp_regs_pkg::RAMP_WMASK) == 8'h00);
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved bits changed");

endmodule // amp_ctrl_regs

// file: amp_page_select_and_ramp_config_tb.sv
// Self-checking bench for the amplifier control register bank
`timescale 1ns/100ps
module amp_page_select_and_ramp_config_tb;
  localparam int         LOADS = 8;
  localparam logic [7:0] IDV   = 8'h5C; // Arbitrary identity value
  logic        pclk, presetn, psel, penable, pwrite, die_overtemp, sense_sample, err;
  logic        pready, pslverr, irq, amp_shutdown, spread_spectrum_modulation;
  logic        boost_enable, passthrough_on, sense_stream_valid, config_loading;
  logic [9:0]  paddr;
  logic [31:0] pwdata, prdata, rd, sense_stream_data;
  logic [3:0]  pstrb;
  logic [7:0]  output_demand;
  logic [15:0] load_current, load_voltage;
  logic [1:0]  ramp_freq_sel, ramp_spread_depth, f, d;
  int          n_errors, tests_run, n;

  amp_ctrl_regs #(.LOAD_CYCLES(LOADS), .ID_CODE(IDV)) i_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .irq(irq), .die_overtemp(die_overtemp), .amp_shutdown(amp_shutdown),
    .ramp_freq_sel(ramp_freq_sel), .ramp_spread_depth(ramp_spread_depth),
    .spread_spectrum_modulation(spread_spectrum_modulation), .output_demand(output_demand),
    .boost_enable(boost_enable), .passthrough_on(passthrough_on), .sense_sample(sense_sample),
    .load_current(load_current), .load_voltage(load_voltage), .sense_stream_data(sense_stream_data),
    .sense_stream_valid(sense_stream_valid), .config_loading(config_loading)
  );

  initial pclk = 1'b0;
  always #5 pclk = ~pclk;

  task give_verdict;
    $display("Counts: %0d compares, %0d mismatches", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %0t %s got %h expected %h", $time, m, got, exp);
    end
  endtask

  task cyc(input int k);
    repeat (k) @(negedge pclk);
  endtask

  // One APB transfer; request held until pready is seen high at a rising edge
  task automatic apb(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
    int w;
    w = 0;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= {idx, 2'b00};
    pwdata  <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      w++;
    end while (pready !== 1'b1 && w < 100);
    if (pready !== 1'b1) begin
      n_errors++;
      $display("[FAIL] %0t bus answer timed out", $time);
      give_verdict;
    end
    rd      = prdata;
    err     = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  initial begin
    {psel, penable, pwrite, die_overtemp, sense_sample} = '0;
    paddr = '0;
    pwdata = '0;
    pstrb = 4'hF;
    output_demand = 8'h10;
    load_current = '0;
    load_voltage = '0;
    n_errors = 0;
    tests_run = 0;
    presetn = 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(negedge pclk);
    chk(config_loading, 32'h1, "loading after reset");
    chk(pready, 32'h0, "stall during load");
    apb(1'b0, amp_regs_pkg::IDX_PAGE, 32'h0);
    chk(rd, 32'h1, "page reset");
    apb(1'b0, amp_regs_pkg::IDX_ID, 32'h0);
    chk(rd, {24'h0, IDV}, "identity");
    apb(1'b1, amp_regs_pkg::IDX_ID, 32'hFF);
    apb(1'b0, amp_regs_pkg::IDX_ID, 32'h0);
    chk(rd, {24'h0, IDV}, "identity after write");
    apb(1'b0, amp_regs_pkg::IDX_RAMP, 32'h0);
    chk(err, 32'h1, "ramp off page 2");
    $display("Test reset and page 1 done");

    apb(1'b1, amp_regs_pkg::IDX_PAGE, 32'h2);
    apb(1'b0, amp_regs_pkg::IDX_RAMP, 32'h0);
    chk(rd, 32'h0, "ramp reset");
    chk(err, 32'h0, "ramp on page 2");
    apb(1'b0, amp_regs_pkg::IDX_PROT, 32'h0);
    chk(rd, 32'h3, "protection reset");
    apb(1'b1, amp_regs_pkg::IDX_RAMP, 32'hFF);
    apb(1'b0, amp_regs_pkg::IDX_RAMP, 32'h0);
    chk(rd, 32'h33, "ramp reserved bits");
    apb(1'b1, amp_regs_pkg::IDX_BOOST, 32'h8005);
    for (int i = 0; i < 3; i++) begin
      f = i[1:0];
      d = (i % 2 == 0) ? amp_regs_pkg::DEPTH_5PCT : amp_regs_pkg::DEPTH_10PCT;
      apb(1'b1, amp_regs_pkg::IDX_RAMP, {26'h0, f, 2'h0, d});
      cyc(1);
      chk(ramp_freq_sel, {30'h0, f}, "ramp rate");
      chk(ramp_spread_depth, {30'h0, d}, "spread depth");
      chk(spread_spectrum_modulation, 32'h1, "spread on");
    end
    apb(1'b1, amp_regs_pkg::IDX_BOOST, 32'h8001);
    cyc(1);
    chk(ramp_spread_depth, 32'h0, "depth with spread off");
    chk(spread_spectrum_modulation, 32'h0, "spread off");
    $display("Test ramp done");

    apb(1'b1, amp_regs_pkg::IDX_PROT, 32'hFF);
    apb(1'b0, amp_regs_pkg::IDX_PROT, 32'h0);
    chk(rd, 32'h7, "protection write");
    @(posedge pclk);
    die_overtemp <= 1'b1;
    cyc(3);
    chk(amp_shutdown, 32'h1, "overtemp shutdown");
    @(posedge pclk);
    die_overtemp <= 1'b0;
    cyc(3);
    chk(amp_shutdown, 32'h1, "held without retry");
    apb(1'b1, amp_regs_pkg::IDX_STAT, 32'h1);
    cyc(2);
    chk(amp_shutdown, 32'h0, "released after clear");
    apb(1'b1, amp_regs_pkg::IDX_PROT, 32'h3);
    @(posedge pclk);
    die_overtemp <= 1'b1;
    cyc(3);
    chk(amp_shutdown, 32'h1, "overtemp shutdown");
    @(posedge pclk);
    die_overtemp <= 1'b0;
    cyc(3);
    chk(amp_shutdown, 32'h0, "auto retry");
    $display("Test protection done");

    chk(boost_enable, 32'h0, "boost off at low power");
    chk(passthrough_on, 32'h1, "passthrough at low power");
    @(posedge pclk);
    output_demand <= 8'hF0;
    cyc(2);
    chk(boost_enable, 32'h1, "boost on at high power");
    chk(passthrough_on, 32'h0, "passthrough off");
    apb(1'b0, amp_regs_pkg::IDX_BOOST, 32'h0);
    chk(rd, 32'h00018001, "boost register with boost on");
    @(posedge pclk);
    output_demand <= 8'h10;
    cyc(5);
    chk(boost_enable, 32'h1, "boost hold");
    cyc(20);
    chk(boost_enable, 32'h0, "boost released");
    apb(1'b1, amp_regs_pkg::IDX_BOOST, 32'h8003);
    cyc(2);
    chk(boost_enable, 32'h1, "forced boost at low power");
    $display("Test boost done");

    apb(1'b0, amp_regs_pkg::IDX_STAT, 32'h0);
    chk(rd, 32'hB, "overtemp, boost and load events latched");
    apb(1'b1, amp_regs_pkg::IDX_STAT, 32'hF);
    @(posedge pclk);
    sense_sample <= 1'b1;
    load_current <= 16'h1234;
    load_voltage <= 16'hABCD;
    @(posedge pclk);
    sense_sample <= 1'b0;
    n = 0;
    @(negedge pclk);
    while (sense_stream_valid !== 1'b1 && n < 3) begin
      @(negedge pclk);
      n++;
    end
    chk(sense_stream_valid, 32'h1, "sense valid");
    chk(sense_stream_data, 32'hABCD1234, "sense data");
    cyc(2);
    chk(irq, 32'h0, "irq masked");
    apb(1'b1, amp_regs_pkg::IDX_MASK, 32'h4);
    cyc(1);
    chk(irq, 32'h1, "irq unmasked");
    apb(1'b1, amp_regs_pkg::IDX_STAT, 32'h4);
    cyc(1);
    chk(irq, 32'h0, "irq cleared");
    apb(1'b0, 8'h10, 32'h0);
    chk(err, 32'h1, "unmapped index");
    $display("Test sense and interrupt done");

    apb(1'b1, amp_regs_pkg::IDX_BOOST, 32'h8009);
    cyc(1);
    chk(config_loading, 32'h1, "reload after soft reset");
    apb(1'b0, amp_regs_pkg::IDX_PAGE, 32'h0);
    chk(rd, 32'h1, "page after soft reset");
    apb(1'b1, amp_regs_pkg::IDX_PAGE, 32'h2);
    apb(1'b0, amp_regs_pkg::IDX_PROT, 32'h0);
    chk(rd, 32'h3, "protection after soft reset");
    $display("Test soft reset done");
    give_verdict;
  end
endmodule // amp_page_select_and_ramp_config_tb
